/* File: hw/lsbe_exec.sv */
// Execution unit for data transfer, stack, I/O bit and rotate/transfer-flag instructions
// Notes on behaviour
// RULE_01 - Post-increment load reads byte at pointer, then pointer plus one; 2 cycles.
// RULE_02 - Pre-decrement load lowers pointer first, reads new address; 2 cycles, no flags.
// RULE_03 - Displaced load reads Y or Z plus displacement; pointer kept; 2 cycles.
// RULE_04 - Direct load reads byte at instruction address; 2 cycles, flags kept.
// RULE_05 - Post-increment store writes at pointer, then pointer plus one; 2 cycles.
// RULE_06 - Pre-decrement store lowers pointer, writes at new address; 2 cycles.
// RULE_07 - Displaced store writes at Y or Z plus displacement; pointer kept; 2 cycles.
// RULE_08 - Direct store writes at instruction address; 2 cycles, flags kept.
// RULE_09 - Push writes register onto stack; 2 cycles, no flag change.
// RULE_10 - Pop loads register from stack top; 2 cycles, no flag change.
// RULE_11 - I/O bit set forces one bit high, others kept; 2 cycles.
// RULE_12 - I/O bit clear forces one bit low, others kept; 2 cycles.
// RULE_13 - Rotate left through carry; updates Z, C, N, V in 1 cycle.
// RULE_14 - Rotate right through carry; updates Z, C, N, V in 1 cycle.
// RULE_15 - Bit store copies selected register bit into transfer flag in 1 cycle.
// RULE_16 - Bit load copies transfer flag into selected register bit; flags kept.
// RULE_17 - Clear-signed instruction clears only the signed-test flag.
// RULE_18 - Pointer steps act on full 16-bit pair and wrap modulo 65536.
`timescale 1ns/10ps
`default_nettype none
`include "lsbe_params.svh"
module lsbe_exec (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Instruction issue
    input  wire logic               start,
    input  wire lsbe_pkg::lsbe_instr_t instr,
    output logic                    busy,
    output logic                    done,
    // Data memory, read data valid in the cycle of mem_re
    output logic [15:0]             mem_addr,
    output logic                    mem_re,
    output logic                    mem_we,
    output logic [7:0]              mem_wdata,
    input  wire logic [7:0]         mem_rdata,
    // I/O space, read data valid in the cycle of io_re
    output logic [5:0]              io_addr,
    output logic                    io_re,
    output logic                    io_we,
    output logic [7:0]              io_wdata,
    input  wire logic [7:0]         io_rdata,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    // Status view
    output logic [7:0]              status
);
    import lsbe_pkg::*;

    function automatic logic [4:0] ptr_lo(input lsbe_ptr_t p);
        unique case (p)
            PTR_X:   ptr_lo = `LSBE_PTR_X_LO;
            PTR_Y:   ptr_lo = `LSBE_PTR_Y_LO;
            PTR_Z:   ptr_lo = `LSBE_PTR_Z_LO;
            default: ptr_lo = `LSBE_PTR_Z_LO;
        endcase
    endfunction

    // Flags after a rotate: V and S follow from the new N and C
    function automatic logic [7:0] rot_flags(input logic [7:0] old, input logic [7:0] res,
                                             input logic c);
        logic [7:0] f;
        f = old;
        f[`LSBE_FLG_C] = c;
        f[`LSBE_FLG_Z] = (res == 8'h00);
        f[`LSBE_FLG_N] = res[7];
        f[`LSBE_FLG_V] = res[7] ^ c;
        f[`LSBE_FLG_S] = c;
        return f;
    endfunction

    lsbe_state_t  state_reg,  state_next;
    lsbe_instr_t  cmd_reg,    cmd_next;
    logic [7:0]   status_reg, status_next;
    logic [15:0]  sp_reg,     sp_next;
    logic         busy_reg,   busy_next;
    logic         done_reg,   done_next;
    logic [15:0]  mem_addr_reg,  mem_addr_next;
    logic         mem_re_reg,    mem_re_next;
    logic         mem_we_reg,    mem_we_next;
    logic [7:0]   mem_wdata_reg, mem_wdata_next;
    logic [5:0]   io_addr_reg,   io_addr_next;
    logic         io_re_reg,     io_re_next;
    logic         io_we_reg,     io_we_next;
    logic [7:0]   io_wdata_reg,  io_wdata_next;
    logic [7:0]   bus_rdata_reg, bus_rdata_next;
    logic [7:0]   rf [32];
    logic         rf_we, ptr_we, accept, bus_wr_ok;
    logic [4:0]   rf_idx, ptr_idx;
    logic [15:0]  ptr_val, ptr_cur, ptr_view;
    logic [7:0]   rf_data, src_cur, data_view, rot_res;

    assign accept    = start && (state_reg == ST_IDLE);
    // Software writes only land while the core is idle, so they never race a core write
    assign bus_wr_ok = reg_wr && !start && (state_reg == ST_IDLE);
    assign ptr_cur   = {rf[5'(ptr_lo(instr.ptr) + 5'h01)], rf[ptr_lo(instr.ptr)]};
    assign ptr_view  = {rf[5'(ptr_lo(cmd_reg.ptr) + 5'h01)], rf[ptr_lo(cmd_reg.ptr)]};
    assign src_cur   = rf[instr.gpr];
    assign data_view = rf[cmd_reg.gpr];

    always_comb begin
        state_next     = state_reg;
        cmd_next       = cmd_reg;
        status_next    = status_reg;
        sp_next        = sp_reg;
        busy_next      = busy_reg;
        done_next      = 1'b0;
        mem_addr_next  = mem_addr_reg;
        mem_re_next    = 1'b0;
        mem_we_next    = 1'b0;
        mem_wdata_next = mem_wdata_reg;
        io_addr_next   = io_addr_reg;
        io_re_next     = 1'b0;
        io_we_next     = 1'b0;
        io_wdata_next  = io_wdata_reg;
        rf_we          = 1'b0;
        rf_idx         = instr.gpr;
        rf_data        = src_cur;
        ptr_we         = 1'b0;
        ptr_idx        = ptr_lo(cmd_reg.ptr);
        ptr_val        = mem_addr_reg;
        rot_res        = 8'h00;
        unique case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    cmd_next   = instr;
                    state_next = ST_FINISH;
                    busy_next  = 1'b1;
                    mem_wdata_next = src_cur;
                    unique case (instr.op)
                        OP_LOAD_INDIRECT, OP_STORE_INDIRECT: begin
                            // Pre-decrement address formed before the access [RULE_02] [RULE_06]
                            mem_addr_next = (instr.mode == PMODE_PRE_DEC) ?
                                            16'(ptr_cur - 16'h0001) : ptr_cur; // [RULE_18]
                            mem_re_next   = (instr.op == OP_LOAD_INDIRECT);
                            mem_we_next   = (instr.op == OP_STORE_INDIRECT);
                        end
                        OP_LOAD_DISPLACED, OP_STORE_DISPLACED: begin
                            mem_addr_next = 16'(ptr_cur + {10'h000, instr.disp}); // [RULE_03] [RULE_07]
                            mem_re_next   = (instr.op == OP_LOAD_DISPLACED);
                            mem_we_next   = (instr.op == OP_STORE_DISPLACED);
                        end
                        OP_LOAD_DIRECT, OP_STORE_DIRECT: begin
                            mem_addr_next = instr.addr; // [RULE_04] [RULE_08]
                            mem_re_next   = (instr.op == OP_LOAD_DIRECT);
                            mem_we_next   = (instr.op == OP_STORE_DIRECT);
                        end
                        OP_PUSH: begin
                            mem_addr_next = sp_reg; // [RULE_09]
                            mem_we_next   = 1'b1;
                        end
                        OP_POP: begin
                            mem_addr_next = 16'(sp_reg + 16'h0001); // [RULE_10]
                            mem_re_next   = 1'b1;
                        end
                        OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
                            io_addr_next = instr.io_addr;
                            io_re_next   = 1'b1;
                        end
                        default: begin
                            // Single-cycle group finishes at the accepting edge
                            state_next = ST_IDLE;
                            busy_next  = 1'b0;
                            done_next  = 1'b1;
                            if (instr.op == OP_ROTATE_LEFT_CARRY) begin
                                rot_res     = {src_cur[6:0], status_reg[`LSBE_FLG_C]}; // [RULE_13]
                                rf_we       = 1'b1;
                                rf_data     = rot_res;
                                status_next = rot_flags(status_reg, rot_res, src_cur[7]);
                            end else if (instr.op == OP_ROTATE_RIGHT_CARRY) begin
                                rot_res     = {status_reg[`LSBE_FLG_C], src_cur[7:1]}; // [RULE_14]
                                rf_we       = 1'b1;
                                rf_data     = rot_res;
                                status_next = rot_flags(status_reg, rot_res, src_cur[0]);
                            end else if (instr.op == OP_BIT_TO_TRANSFER_FLAG) begin
                                status_next[`LSBE_FLG_T] = src_cur[instr.bit_sel]; // [RULE_15]
                            end else if (instr.op == OP_BIT_FROM_TRANSFER_FLAG) begin
                                rf_we   = 1'b1;
                                rf_data[instr.bit_sel] = status_reg[`LSBE_FLG_T]; // [RULE_16]
                            end else if (instr.op == OP_CLEAR_SIGNED) begin
                                status_next[`LSBE_FLG_S] = 1'b0; // [RULE_17]
                            end
                        end
                    endcase
                end else if (bus_wr_ok) begin
                    rf_idx  = reg_addr[4:0];
                    rf_data = reg_wdata;
                    rf_we   = (reg_addr <= `LSBE_OFS_GPR_LAST);
                    if (reg_addr == `LSBE_OFS_STATUS) status_next = reg_wdata;
                    if (reg_addr == `LSBE_OFS_SP_LO)  sp_next[7:0] = reg_wdata;
                    if (reg_addr == `LSBE_OFS_SP_HI)  sp_next[15:8] = reg_wdata;
                end
            end
            ST_FINISH: begin
                state_next = ST_IDLE;
                busy_next  = 1'b0;
                done_next  = 1'b1;
                rf_idx     = cmd_reg.gpr;
                rf_data    = mem_rdata;
                rf_we      = mem_re_reg; // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_10]
                if ((cmd_reg.op == OP_LOAD_INDIRECT) || (cmd_reg.op == OP_STORE_INDIRECT)) begin
                    // Pre-decrement value already sits in the address register
                    ptr_we  = (cmd_reg.mode != PMODE_PLAIN); // [RULE_02] [RULE_06]
                    ptr_val = (cmd_reg.mode == PMODE_POST_INC) ?
                              16'(mem_addr_reg + 16'h0001) : mem_addr_reg; // [RULE_01] [RULE_05] [RULE_18]
                end
                if (cmd_reg.op == OP_PUSH) sp_next = 16'(sp_reg - 16'h0001); // [RULE_09]
                if (cmd_reg.op == OP_POP) sp_next = mem_addr_reg; // [RULE_10]
                if (cmd_reg.op == OP_IO_BIT_SET || cmd_reg.op == OP_IO_BIT_CLEAR) begin
                    io_we_next = 1'b1;
                    io_wdata_next = io_rdata;
                    io_wdata_next[cmd_reg.bit_sel] = (cmd_reg.op == OP_IO_BIT_SET); // [RULE_11] [RULE_12]
                end
            end
        endcase
        bus_rdata_next = 8'h00;
        if (reg_rd && reg_addr <= `LSBE_OFS_GPR_LAST) bus_rdata_next = rf[reg_addr[4:0]];
        else if (reg_rd && reg_addr == `LSBE_OFS_STATUS) bus_rdata_next = status_reg;
        else if (reg_rd && reg_addr == `LSBE_OFS_SP_LO) bus_rdata_next = sp_reg[7:0];
        else if (reg_rd && reg_addr == `LSBE_OFS_SP_HI) bus_rdata_next = sp_reg[15:8];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            cmd_reg       <= '0;
            status_reg    <= `LSBE_RST_STATUS;
            sp_reg        <= `LSBE_RST_SP;
            busy_reg      <= 1'b0;
            done_reg      <= 1'b0;
            mem_addr_reg  <= 16'h0000;
            mem_re_reg    <= 1'b0;
            mem_we_reg    <= 1'b0;
            mem_wdata_reg <= 8'h00;
            io_addr_reg   <= 6'h00;
            io_re_reg     <= 1'b0;
            io_we_reg     <= 1'b0;
            io_wdata_reg  <= 8'h00;
            bus_rdata_reg <= 8'h00;
            for (int i = 0; i < 32; i++) rf[i] <= `LSBE_RST_GPR;
        end else begin
            state_reg     <= state_next;
            cmd_reg       <= cmd_next;
            status_reg    <= status_next;
            sp_reg        <= sp_next;
            busy_reg      <= busy_next;
            done_reg      <= done_next;
            mem_addr_reg  <= mem_addr_next;
            mem_re_reg    <= mem_re_next;
            mem_we_reg    <= mem_we_next;
            mem_wdata_reg <= mem_wdata_next;
            io_addr_reg   <= io_addr_next;
            io_re_reg     <= io_re_next;
            io_we_reg     <= io_we_next;
            io_wdata_reg  <= io_wdata_next;
            bus_rdata_reg <= bus_rdata_next;
            // Data write follows the pointer write so it wins on overlap
            if (ptr_we) begin
                rf[ptr_idx]                <= ptr_val[7:0];
                rf[5'(ptr_idx + 5'h01)]    <= ptr_val[15:8];
            end
            if (rf_we) rf[rf_idx] <= rf_data;
        end
    end

    assign busy      = busy_reg;
    assign done      = done_reg;
    assign mem_addr  = mem_addr_reg;
    assign mem_re    = mem_re_reg;
    assign mem_we    = mem_we_reg;
    assign mem_wdata = mem_wdata_reg;
    assign io_addr   = io_addr_reg;
    assign io_re     = io_re_reg;
    assign io_we     = io_we_reg;
    assign io_wdata  = io_wdata_reg;
    assign reg_rdata = bus_rdata_reg;
    assign status    = status_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence two_cycle_end;
        busy_reg ##1 (done_reg && !busy_reg);
    endsequence
    AST_LOAD_POST_INC: assert property ( // [RULE_01]
        accept && instr.op == OP_LOAD_INDIRECT && instr.mode == PMODE_POST_INC
        |=> (mem_re_reg && mem_addr_reg == $past(ptr_cur))
            ##1 (done_reg && ptr_view == 16'($past(mem_addr_reg) + 16'h0001)))
        else $error("post-increment load address or pointer step wrong");
    AST_LOAD_PRE_DEC: assert property ( // [RULE_02]
        accept && instr.op == OP_LOAD_INDIRECT && instr.mode == PMODE_PRE_DEC
        |=> (mem_addr_reg == 16'($past(ptr_cur) - 16'h0001))
            ##1 (ptr_view == $past(mem_addr_reg)))
        else $error("pre-decrement load address or pointer wrong");
    AST_LOAD_DISPLACED: assert property ( // [RULE_03]
        accept && instr.op == OP_LOAD_DISPLACED
        |=> (mem_addr_reg == 16'($past(ptr_cur) + {10'h000, $past(instr.disp)}))
            ##1 (ptr_view == $past(ptr_view) && data_view == $past(mem_rdata)))
        else $error("displaced load wrong");
    AST_STORE_DATA: assert property ( // [RULE_05]
        accept && instr.op == OP_STORE_INDIRECT
        |=> mem_we_reg && !mem_re_reg && mem_wdata_reg == $past(src_cur))
        else $error("store data not driven");
    AST_PUSH_STACK: assert property ( // [RULE_09]
        accept && instr.op == OP_PUSH
        |=> (mem_we_reg && mem_addr_reg == $past(sp_reg))
            ##1 (sp_reg == 16'($past(mem_addr_reg) - 16'h0001)))
        else $error("push address or stack step wrong");
    AST_IO_BIT_SET: assert property ( // [RULE_11]
        state_reg == ST_FINISH && cmd_reg.op == OP_IO_BIT_SET
        |=> io_we_reg && io_wdata_reg == ($past(io_rdata) | (8'h01 << $past(cmd_reg.bit_sel))))
        else $error("I/O bit set result wrong");
    AST_ROTATE_LEFT: assert property ( // [RULE_13]
        accept && instr.op == OP_ROTATE_LEFT_CARRY
        |=> done_reg && data_view == {$past(src_cur[6:0]), $past(status_reg[0])}
            && status_reg[0] == $past(src_cur[7]))
        else $error("rotate left through carry wrong");
    AST_BIT_TO_T: assert property ( // [RULE_15]
        accept && instr.op == OP_BIT_TO_TRANSFER_FLAG
        |=> status_reg[6] == $past(src_cur[instr.bit_sel]))
        else $error("transfer flag not copied");
    AST_CLEAR_SIGNED: assert property ( // [RULE_17]
        accept && instr.op == OP_CLEAR_SIGNED
        |=> status_reg == ($past(status_reg) & 8'hEF))
        else $error("clear signed touched other flags");
    AST_LONG_FLAGS: assert property ( // [RULE_08]
        accept && (instr.op <= OP_IO_BIT_CLEAR)
        |=> two_cycle_end ##0 status_reg == $past(status_reg, 2))
        else $error("two-cycle instruction timing or flags wrong");
endmodule

`default_nettype wire

/* File: hw/lsbe_params.svh */
// Offsets, field positions, reset values and cycle counts of the load/store/bit execution unit
`ifndef LSBE_PARAMS_SVH
`define LSBE_PARAMS_SVH

// Register port offsets; general registers occupy 8'h00 to 8'h1F
`define LSBE_OFS_GPR_LAST   8'h1F
`define LSBE_OFS_STATUS     8'h20
`define LSBE_OFS_SP_LO      8'h21
`define LSBE_OFS_SP_HI      8'h22

// Status register bit positions
`define LSBE_FLG_C          3'h0
`define LSBE_FLG_Z          3'h1
`define LSBE_FLG_N          3'h2
`define LSBE_FLG_V          3'h3
`define LSBE_FLG_S          3'h4
`define LSBE_FLG_T          3'h6

// Low byte of each pointer pair in the register file
`define LSBE_PTR_X_LO       5'h1A
`define LSBE_PTR_Y_LO       5'h1C
`define LSBE_PTR_Z_LO       5'h1E

// Reset values
`define LSBE_RST_STATUS     8'h00
`define LSBE_RST_SP         16'h0000
`define LSBE_RST_GPR        8'h00

// Cycle counts of the two instruction classes
`define LSBE_CYC_SHORT      1
`define LSBE_CYC_LONG       2

`endif

/* File: hw/lsbe_pkg.sv */
// Types of the load/store/bit execution unit
`default_nettype none
package lsbe_pkg;

    typedef enum logic [3:0] {
        OP_LOAD_INDIRECT,
        OP_LOAD_DISPLACED,
        OP_LOAD_DIRECT,
        OP_STORE_INDIRECT,
        OP_STORE_DISPLACED,
        OP_STORE_DIRECT,
        OP_PUSH,
        OP_POP,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_BIT_TO_TRANSFER_FLAG,
        OP_BIT_FROM_TRANSFER_FLAG,
        OP_CLEAR_SIGNED
    } lsbe_op_t;

    typedef enum logic [1:0] {
        PTR_X,
        PTR_Y,
        PTR_Z
    } lsbe_ptr_t;

    typedef enum logic [1:0] {
        PMODE_PLAIN,
        PMODE_POST_INC,
        PMODE_PRE_DEC
    } lsbe_pmode_t;

    typedef enum logic {
        ST_IDLE,
        ST_FINISH
    } lsbe_state_t;

    typedef struct packed {
        lsbe_op_t    op;
        logic [4:0]  gpr;
        lsbe_ptr_t   ptr;
        lsbe_pmode_t mode;
        logic [5:0]  disp;
        logic [15:0] addr;
        logic [5:0]  io_addr;
        logic [2:0]  bit_sel;
    } lsbe_instr_t;

endpackage

`default_nettype wire

/* File: testbench/lsbe_mem_model.sv */
// Data memory and I/O space seen by the execution unit
`timescale 1ns/10ps
`default_nettype none

module lsbe_mem_model (
    // Clock
    input  wire logic        sys_clk,
    // Data memory
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_re,
    input  wire logic        mem_we,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata,
    // I/O space
    input  wire logic [5:0]  io_addr,
    input  wire logic        io_re,
    input  wire logic        io_we,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] io  [0:63];
    logic [7:0] junk = 8'h5A;

    // Read data toggles outside a read, so a late sample cannot pass by luck
    always @(posedge sys_clk) begin
        junk <= ~junk;
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (io_we) begin
            io[io_addr] <= io_wdata;
        end
    end

    assign mem_rdata = mem_re ? mem[mem_addr] : junk;
    assign io_rdata  = io_re ? io[io_addr] : junk;
endmodule

`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the load/store/bit execution unit
`timescale 1ns/10ps
`default_nettype none

module tb;
    import lsbe_pkg::*;
    logic        sys_clk, rst_n, start, busy, done, reg_wr, reg_rd;
    logic        mem_re, mem_we, io_re, io_we;
    lsbe_instr_t instr;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata, mem_rdata, io_wdata, io_rdata;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, status;
    logic [5:0]  io_addr;
    int          miscompares, checks;

    lsbe_exec dut_u (.sys_clk, .rst_n, .start, .instr, .busy, .done, .mem_addr, .mem_re,
        .mem_we, .mem_wdata, .mem_rdata, .io_addr, .io_re, .io_we, .io_wdata, .io_rdata,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .status);
    lsbe_mem_model mem_u (.sys_clk, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata,
        .io_addr, .io_re, .io_we, .io_wdata, .io_rdata);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, e}, "register");
    endtask

    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 8'h01, e[15:8]);
    endtask

    // Address argument also carries displacement, I/O address and bit select
    function automatic lsbe_instr_t ins(lsbe_op_t op, logic [4:0] g, lsbe_ptr_t p,
                                        lsbe_pmode_t m, logic [15:0] a);
        lsbe_instr_t r;
        r.op      = op;
        r.gpr     = g;
        r.ptr     = p;
        r.mode    = m;
        r.disp    = a[5:0];
        r.addr    = a;
        r.io_addr = a[5:0];
        r.bit_sel = a[10:8];
        return r;
    endfunction

    task automatic ex(input lsbe_instr_t i, input int cyc, input logic [7:0] st);
        int n;
        @(posedge sys_clk);
        start <= 1'b1;
        instr <= i;
        @(posedge sys_clk);
        start <= 1'b0;
        n = 1;
        #1 chk({15'h0, busy}, {15'h0, cyc == 2}, "busy");
        while (done !== 1'b1 && n < 6) begin
            @(posedge sys_clk);
            n++;
            #1;
        end
        chk(16'(n), 16'(cyc), "cycles");
        chk({8'h00, status}, {8'h00, st}, "status");
    endtask

    task automatic mchk(input logic [15:0] a, input logic [7:0] e);
        chk({8'h00, mem_u.mem[a]}, {8'h00, e}, "memory");
    endtask

    // The I/O write strobe stands in the done cycle, so the byte lands one edge later
    task automatic iochk(input logic [5:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        #1 chk({8'h00, mem_u.io[a]}, {8'h00, e}, "io");
    endtask

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge sys_clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        {rst_n, start, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        instr = '0;
        mem_u.mem[16'h00FF] = 8'hA5;
        mem_u.mem[16'hFFFF] = 8'h3C;
        mem_u.mem[16'h103F] = 8'hC3;
        mem_u.mem[16'hBEEF] = 8'h7E;
        mem_u.io[5] = 8'h01;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h20, 8'h00);
        rd16(8'h21, 16'h0000);
        rd(8'h1A, 8'h00);
        rd(8'h30, 8'h00);
        $display("test reset done");
        wr(8'h20, 8'h4B);
        wr(8'h1A, 8'hFF);
        wr(8'h1F, 8'h10);
        ex(ins(OP_LOAD_INDIRECT, 5, PTR_X, PMODE_POST_INC, 0), 2, 8'h4B);
        rd(8'h05, 8'hA5);
        rd16(8'h1A, 16'h0100);
        ex(ins(OP_LOAD_INDIRECT, 6, PTR_Y, PMODE_PRE_DEC, 0), 2, 8'h4B);
        rd(8'h06, 8'h3C);
        rd16(8'h1C, 16'hFFFF);
        ex(ins(OP_LOAD_DISPLACED, 7, PTR_Z, PMODE_PLAIN, 16'h003F), 2, 8'h4B);
        rd(8'h07, 8'hC3);
        rd16(8'h1E, 16'h1000);
        ex(ins(OP_LOAD_DIRECT, 8, PTR_X, PMODE_PLAIN, 16'hBEEF), 2, 8'h4B);
        rd(8'h08, 8'h7E);
        $display("test loads done");
        wr(8'h09, 8'h5A);
        ex(ins(OP_STORE_INDIRECT, 9, PTR_X, PMODE_POST_INC, 0), 2, 8'h4B);
        mchk(16'h0100, 8'h5A);
        rd16(8'h1A, 16'h0101);
        ex(ins(OP_STORE_INDIRECT, 9, PTR_Y, PMODE_PRE_DEC, 0), 2, 8'h4B);
        mchk(16'hFFFE, 8'h5A);
        rd16(8'h1C, 16'hFFFE);
        ex(ins(OP_STORE_DISPLACED, 9, PTR_Z, PMODE_PLAIN, 16'h0001), 2, 8'h4B);
        mchk(16'h1001, 8'h5A);
        rd16(8'h1E, 16'h1000);
        ex(ins(OP_STORE_INDIRECT, 9, PTR_Z, PMODE_PLAIN, 0), 2, 8'h4B);
        mchk(16'h1000, 8'h5A);
        rd16(8'h1E, 16'h1000);
        ex(ins(OP_STORE_DIRECT, 9, PTR_X, PMODE_PLAIN, 16'h2222), 2, 8'h4B);
        mchk(16'h2222, 8'h5A);
        $display("test stores done");
        wr(8'h22, 8'h03);
        ex(ins(OP_PUSH, 9, PTR_X, PMODE_PLAIN, 0), 2, 8'h4B);
        mchk(16'h0300, 8'h5A);
        rd16(8'h21, 16'h02FF);
        ex(ins(OP_POP, 10, PTR_X, PMODE_PLAIN, 0), 2, 8'h4B);
        rd(8'h0A, 8'h5A);
        rd16(8'h21, 16'h0300);
        ex(ins(OP_IO_BIT_SET, 0, PTR_X, PMODE_PLAIN, 16'h0705), 2, 8'h4B);
        iochk(6'h05, 8'h81);
        ex(ins(OP_IO_BIT_CLEAR, 0, PTR_X, PMODE_PLAIN, 16'h0005), 2, 8'h4B);
        iochk(6'h05, 8'h80);
        $display("test stack and io done");
        wr(8'h20, 8'h01);
        wr(8'h0B, 8'h80);
        ex(ins(OP_ROTATE_LEFT_CARRY, 11, PTR_X, PMODE_PLAIN, 0), 1, 8'h19);
        rd(8'h0B, 8'h01);
        wr(8'h0C, 8'h01);
        ex(ins(OP_ROTATE_RIGHT_CARRY, 12, PTR_X, PMODE_PLAIN, 0), 1, 8'h15);
        rd(8'h0C, 8'h80);
        wr(8'h20, 8'h00);
        wr(8'h0D, 8'h01);
        ex(ins(OP_ROTATE_RIGHT_CARRY, 13, PTR_X, PMODE_PLAIN, 0), 1, 8'h1B);
        rd(8'h0D, 8'h00);
        wr(8'h0E, 8'h20);
        ex(ins(OP_BIT_TO_TRANSFER_FLAG, 14, PTR_X, PMODE_PLAIN, 16'h0500), 1, 8'h5B);
        ex(ins(OP_BIT_FROM_TRANSFER_FLAG, 15, PTR_X, PMODE_PLAIN, 16'h0200), 1, 8'h5B);
        rd(8'h0F, 8'h04);
        ex(ins(OP_CLEAR_SIGNED, 0, PTR_X, PMODE_PLAIN, 0), 1, 8'h4B);
        $display("test rotate and flags done");
        print_verdict();
    end
endmodule

`default_nettype wire
